/* File: rtl/hpcfg_pkg.sv */
// constants and carriers for the hub power and port configuration bank
// assumes one 40 MHz clock and a byte-wide register port from the config loader
//
// Contract
// - bits 7..1 of the bus-power port mask disable ports 7..1 when set while bus-powered.
// - bit 0 of the bus-power port mask is reserved and always reads zero.
// - the self-power budget byte is an unsigned 2mA-step upstream draw when self-powered.
// - the bus-power budget byte is an unsigned 2mA-step upstream draw when bus-powered.
// - current fields mean value times 2mA, so 50 stands for 100mA.
// - all four registers clear to zero on reset.
// - the power source select bit picks self-powered when one, bus-powered when zero.
// - the compound bit marks whether an embedded peripheral is part of the hub.
package hpcfg_pkg;
  localparam logic [7:0] OFS_PORT_OFF_MASK_BUS   = 8'h0b;
  localparam logic [7:0] OFS_SELF_POWER_BUDGET   = 8'h0c;
  localparam logic [7:0] OFS_BUS_POWER_BUDGET    = 8'h0d;
  localparam logic [7:0] OFS_CTRL_DRAW_SELF      = 8'h0e;
  localparam logic [7:0] RESET_VALUE             = 8'h00;
  localparam logic [7:0] PORT_MASK_WRITABLE      = 8'hfe;
  localparam int         MA_PER_STEP             = 2;
  localparam int         CURRENT_MA_WIDTH        = 9;
  localparam logic [7:0] SELF_POWER_LIMIT_STEPS  = 8'h32;

  typedef struct packed {
    logic [7:0] port_mask;
    logic [7:0] budget;
    logic [8:0] budget_ma;
    logic       over_limit;
  } hpcfg_power_view_t;
endpackage

/* File: rtl/hpcfg_read_mux.sv */
// read data selection for the power configuration bank
// assumes register values stable from the top module; purely combinational
`timescale 1ns/1ps
module hpcfg_read_mux
(
  input  wire logic [7:0] addr,
  input  wire logic [7:0] port_mask,
  input  wire logic [7:0] self_budget,
  input  wire logic [7:0] bus_budget,
  input  wire logic [7:0] ctrl_draw,
  output logic      [7:0] rdata,
  output logic            hit
);
  // decode offset, undefined offsets read zero
  always_comb
  begin
    hit   = 1'b1;
    rdata = hpcfg_pkg::RESET_VALUE;
    case (addr)
      hpcfg_pkg::OFS_PORT_OFF_MASK_BUS:
        rdata = port_mask & hpcfg_pkg::PORT_MASK_WRITABLE;
      hpcfg_pkg::OFS_SELF_POWER_BUDGET: rdata = self_budget;
      hpcfg_pkg::OFS_BUS_POWER_BUDGET:  rdata = bus_budget;
      hpcfg_pkg::OFS_CTRL_DRAW_SELF:    rdata = ctrl_draw;
      default:                          hit   = 1'b0;
    endcase
  end
endmodule

/* File: rtl/hpcfg_regs.sv */
// hub power and port configuration registers with mode-dependent view
// assumes the config loader (eeprom or smbus engine) drives a same-clock byte port
// assumes the power source and compound bits arrive as levels on the same clock
// outputs are registered views; unmapped writes are dropped, unmapped reads give zero
`timescale 1ns/1ps
module hpcfg_regs
(
  input  wire logic                          SYS_CLK,
  input  wire logic                          SYS_RST,
  input  wire logic                          CFG_WR,
  input  wire logic                          CFG_RD,
  input  wire logic [7:0]                    CFG_ADDR,
  input  wire logic [7:0]                    CFG_WDATA,
  input  wire logic                          POWER_SOURCE_SELECT,
  input  wire logic                          COMPOUND_DEVICE,
  output logic      [7:0]                    CFG_RDATA,
  output logic                               CFG_RD_HIT,
  output logic      [7:0]                    PORT_OFF_ACTIVE,
  output logic      [7:0]                    POWER_BUDGET_ACTIVE,
  output logic      [hpcfg_pkg::CURRENT_MA_WIDTH-1:0] POWER_BUDGET_MA,
  output logic      [hpcfg_pkg::CURRENT_MA_WIDTH-1:0] CONTROLLER_DRAW_MA,
  output logic                               SELF_POWER_OVER_LIMIT,
  output logic                               COMPOUND_ACTIVE
);
  logic [7:0]                    port_off_mask_bus_power_reg;
  logic [7:0]                    self_power_budget_reg;
  logic [7:0]                    bus_power_budget_reg;
  logic [7:0]                    controller_draw_self_power_reg;
  logic [7:0]                    rdata_next;
  logic                          hit_next;
  hpcfg_pkg::hpcfg_power_view_t  view_next;

  // true for the four offsets this bank answers
  function automatic logic reg_mapped(input logic [7:0] a);
    return (a >= hpcfg_pkg::OFS_PORT_OFF_MASK_BUS) && (a <= hpcfg_pkg::OFS_CTRL_DRAW_SELF);
  endfunction

  // register writes; bit 0 of the mask is never stored
  // masking on the way in means no read or view can ever show the reserved bit
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      port_off_mask_bus_power_reg    <= hpcfg_pkg::RESET_VALUE;
      self_power_budget_reg          <= hpcfg_pkg::RESET_VALUE;
      bus_power_budget_reg           <= hpcfg_pkg::RESET_VALUE;
      controller_draw_self_power_reg <= hpcfg_pkg::RESET_VALUE;
    end
    else if (CFG_WR)
    begin
      case (CFG_ADDR)
        hpcfg_pkg::OFS_PORT_OFF_MASK_BUS:
          port_off_mask_bus_power_reg <= CFG_WDATA & hpcfg_pkg::PORT_MASK_WRITABLE;
        hpcfg_pkg::OFS_SELF_POWER_BUDGET:
          self_power_budget_reg <= CFG_WDATA;
        hpcfg_pkg::OFS_BUS_POWER_BUDGET:
          bus_power_budget_reg <= CFG_WDATA;
        hpcfg_pkg::OFS_CTRL_DRAW_SELF:
          controller_draw_self_power_reg <= CFG_WDATA;
        default:
          port_off_mask_bus_power_reg <= port_off_mask_bus_power_reg; // unmapped: no effect
      endcase
    end
  end

  hpcfg_read_mux u_read_mux
  (
    .addr        (CFG_ADDR),
    .port_mask   (port_off_mask_bus_power_reg),
    .self_budget (self_power_budget_reg),
    .bus_budget  (bus_power_budget_reg),
    .ctrl_draw   (controller_draw_self_power_reg),
    .rdata       (rdata_next),
    .hit         (hit_next)
  );

  // registered read answer, one cycle after strobe
  // data drops back to zero the cycle after the read strobe goes low so a stale byte is never taken twice
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      CFG_RDATA  <= 8'h00;
      CFG_RD_HIT <= 1'b0;
    end
    else
    begin
      CFG_RDATA  <= CFG_RD ? rdata_next : 8'h00;
      CFG_RD_HIT <= CFG_RD & hit_next;
    end
  end

  // select active settings by power source; bus mask only in bus mode
  // the self-power mask lives outside this bank, so self mode shows no port off
  always_comb
  begin
    if (POWER_SOURCE_SELECT)
    begin
      view_next.port_mask = 8'h00;
      view_next.budget    = self_power_budget_reg;
    end
    else
    begin
      view_next.port_mask = port_off_mask_bus_power_reg;
      view_next.budget    = bus_power_budget_reg;
    end
    view_next.budget_ma  = {view_next.budget, 1'b0};
    view_next.over_limit = (self_power_budget_reg > hpcfg_pkg::SELF_POWER_LIMIT_STEPS) |
                           (controller_draw_self_power_reg > hpcfg_pkg::SELF_POWER_LIMIT_STEPS);
  end

  // registered outputs toward the hub core
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      PORT_OFF_ACTIVE       <= 8'h00;
      POWER_BUDGET_ACTIVE   <= 8'h00;
      POWER_BUDGET_MA       <= '0;
      CONTROLLER_DRAW_MA    <= '0;
      SELF_POWER_OVER_LIMIT <= 1'b0;
      COMPOUND_ACTIVE       <= 1'b0;
    end
    else
    begin
      PORT_OFF_ACTIVE       <= view_next.port_mask;
      POWER_BUDGET_ACTIVE   <= view_next.budget;
      POWER_BUDGET_MA       <= view_next.budget_ma;
      CONTROLLER_DRAW_MA    <= {controller_draw_self_power_reg, 1'b0};
      SELF_POWER_OVER_LIMIT <= view_next.over_limit; // flags a breach of the 100mA cap
      COMPOUND_ACTIVE       <= COMPOUND_DEVICE;
    end
  end

  // stored bytes follow each write to their own offset
  a_mask_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_PORT_OFF_MASK_BUS
    |=> port_off_mask_bus_power_reg == ($past(CFG_WDATA) & hpcfg_pkg::PORT_MASK_WRITABLE))
    else $error("mask store wrong");
  a_self_budget_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_SELF_POWER_BUDGET
    |=> self_power_budget_reg == $past(CFG_WDATA))
    else $error("self budget store wrong");
  a_bus_budget_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_BUS_POWER_BUDGET
    |=> bus_power_budget_reg == $past(CFG_WDATA))
    else $error("bus budget store wrong");
  a_unmapped_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && !reg_mapped(CFG_ADDR)
    |=> $stable(port_off_mask_bus_power_reg) && $stable(self_power_budget_reg) &&
    $stable(bus_power_budget_reg) && $stable(controller_draw_self_power_reg))
    else $error("unmapped write changed a register");

  // read answers, views and reset
  a_mask_bit0_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_RD && CFG_ADDR == hpcfg_pkg::OFS_PORT_OFF_MASK_BUS |=> CFG_RDATA[0] == 1'b0)
    else $error("mask bit 0 read nonzero");
  a_mask_write_read: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_PORT_OFF_MASK_BUS && !CFG_RD ##1
    CFG_RD && !CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_PORT_OFF_MASK_BUS
    |=> CFG_RDATA == ($past(CFG_WDATA, 2) & 8'hfe))
    else $error("mask readback mismatch");
  a_self_budget_rw: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_SELF_POWER_BUDGET ##1
    CFG_RD && !CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_SELF_POWER_BUDGET
    |=> CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("self budget readback mismatch");
  a_bus_budget_rw: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_BUS_POWER_BUDGET ##1
    CFG_RD && !CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_BUS_POWER_BUDGET
    |=> CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("bus budget readback mismatch");
  a_ma_scaling: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    POWER_BUDGET_MA == 9'(POWER_BUDGET_ACTIVE) * 9'd2)
    else $error("budget mA scaling wrong");
  a_reset_clears: assert property (@(posedge SYS_CLK)
    $past(SYS_RST) && SYS_RST |-> port_off_mask_bus_power_reg == 8'h00 &&
    self_power_budget_reg == 8'h00 && bus_power_budget_reg == 8'h00 &&
    controller_draw_self_power_reg == 8'h00)
    else $error("register not cleared by reset");
  a_self_mode_view: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    POWER_SOURCE_SELECT && !(CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_SELF_POWER_BUDGET)
    |=> PORT_OFF_ACTIVE == 8'h00 && POWER_BUDGET_ACTIVE == self_power_budget_reg)
    else $error("self mode view wrong");
  a_bus_mode_view: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !POWER_SOURCE_SELECT && !CFG_WR
    |=> PORT_OFF_ACTIVE == port_off_mask_bus_power_reg &&
    POWER_BUDGET_ACTIVE == bus_power_budget_reg)
    else $error("bus mode view wrong");
  a_compound_follow: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    COMPOUND_DEVICE ##1 COMPOUND_DEVICE |-> COMPOUND_ACTIVE)
    else $error("compound flag not followed");

  // controller draw, over-limit flag and compound copy
  a_ctrl_draw_rw: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_CTRL_DRAW_SELF ##1
    CFG_RD && !CFG_WR && CFG_ADDR == hpcfg_pkg::OFS_CTRL_DRAW_SELF
    |=> CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("controller draw readback mismatch");
  a_ctrl_ma_scaling: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    1'b1 |=> CONTROLLER_DRAW_MA ==
    9'($past(controller_draw_self_power_reg)) * 9'(hpcfg_pkg::MA_PER_STEP))
    else $error("controller draw mA scaling wrong");
  a_over_limit_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    1'b1 |=> SELF_POWER_OVER_LIMIT ==
    ($past(self_power_budget_reg) > hpcfg_pkg::SELF_POWER_LIMIT_STEPS ||
     $past(controller_draw_self_power_reg) > hpcfg_pkg::SELF_POWER_LIMIT_STEPS))
    else $error("over limit flag wrong");
  a_compound_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !COMPOUND_DEVICE |=> !COMPOUND_ACTIVE)
    else $error("compound flag not cleared");

  // reserved bit on the active mask, idle read lines, read hit and reset
  a_port_bit0_idle: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    PORT_OFF_ACTIVE[0] == 1'b0)
    else $error("active port mask bit 0 set");
  a_read_idle_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !CFG_RD |=> CFG_RDATA == 8'h00 && !CFG_RD_HIT)
    else $error("read lines not idle");
  a_read_hit_mapped: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CFG_RD |=> CFG_RD_HIT == reg_mapped($past(CFG_ADDR)))
    else $error("read hit flag wrong");
  a_outputs_reset: assert property (@(posedge SYS_CLK)
    SYS_RST |=> PORT_OFF_ACTIVE == 8'h00 && POWER_BUDGET_ACTIVE == 8'h00 &&
    POWER_BUDGET_MA == 9'h000 && CONTROLLER_DRAW_MA == 9'h000 &&
    !SELF_POWER_OVER_LIMIT && !COMPOUND_ACTIVE && !CFG_RD_HIT && CFG_RDATA == 8'h00)
    else $error("outputs not cleared by reset");
endmodule

/* File: sim/hpcfg_loader_model.sv */
// config loader model: byte writes and reads into the power bank
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
module hpcfg_loader_model
(
  input  wire logic       clk,
  output logic            wr,
  output logic            rd,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       hit
);
  // idle bus at time zero
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // one write strobe; released lines show the inverse
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  // one read strobe, answer taken a cycle later
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    d = rdata;
    h = hit;
    rd = 1'b0;
    addr = ~a;
  endtask
  // write then read the same offset on the very next edge
  task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                            output logic h);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    wdata = ~d;
    @(negedge clk);
    q = rdata;
    h = hit;
    rd = 1'b0;
    addr = ~a;
  endtask
  // one contiguous group of ports between x and y
  function automatic logic [7:0] contig_mask(input logic [2:0] x, input logic [2:0] y);
    logic [7:0] m;
    m = 8'h00;
    for (int p = 1; p <= 7; p++)
      m[p] = (p >= ((x < y) ? x : y)) && (p <= ((x < y) ? y : x));
    return m;
  endfunction
  // self-power values kept within 100mA, peripheral share left to the caller
  function automatic logic [7:0] self_value(input logic [7:0] v);
    return (v > 8'h32) ? v % 8'h33 : v;
  endfunction
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the hub power configuration bank
// assumes the loader model on the byte port and random mode inputs
`timescale 1ns/1ps
module testbench;
  logic       SYS_CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic       sel = 1'b0;
  logic       cmp = 1'b0;
  logic       wr, rd, hit, over, comp_act, rh;
  logic [7:0] addr, wdata, rdata, port_off, budget, rv;
  logic [8:0] budget_ma, ctrl_ma;
  logic [7:0] shadow [11:14];
  int         errors = 0;
  int         samples_checked = 0;
  int         seed = 32'h123b462a;
  int         k;
  // 40 MHz clock
  always #12.5 SYS_CLK = ~SYS_CLK;
  hpcfg_regs i_hpcfg_regs (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(addr), .CFG_WDATA(wdata), .POWER_SOURCE_SELECT(sel), .COMPOUND_DEVICE(cmp),
    .CFG_RDATA(rdata), .CFG_RD_HIT(hit), .PORT_OFF_ACTIVE(port_off),
    .POWER_BUDGET_ACTIVE(budget), .POWER_BUDGET_MA(budget_ma),
    .CONTROLLER_DRAW_MA(ctrl_ma), .SELF_POWER_OVER_LIMIT(over), .COMPOUND_ACTIVE(comp_act));
  hpcfg_loader_model i_hpcfg_loader_model (.clk(SYS_CLK), .wr(wr), .rd(rd), .addr(addr),
    .wdata(wdata), .rdata(rdata), .hit(hit));
  // value and flag comparisons
  task automatic cmp_val(input string what, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_flag(input string what, input logic e, input logic g);
    cmp_val(what, {8'h00, e}, {8'h00, g});
  endtask
  // mode-dependent view worked out from the shadow copy
  task automatic check_view();
    logic [7:0] b;
    b = sel ? shadow[12] : shadow[13];
    cmp_val("port off", sel ? 9'h000 : {1'b0, shadow[11]}, {1'b0, port_off});
    cmp_val("budget", {1'b0, b}, {1'b0, budget});
    cmp_val("budget ma", 9'(b) * 9'(hpcfg_pkg::MA_PER_STEP), budget_ma);
    cmp_val("ctrl ma", 9'(shadow[14]) * 9'(hpcfg_pkg::MA_PER_STEP), ctrl_ma);
    cmp_flag("over", (shadow[12] > 8'h32) || (shadow[14] > 8'h32), over);
    cmp_flag("compound", cmp, comp_act);
  endtask
  // one random write, read back and view check
  task automatic one_step(input int n);
    logic [7:0] a;
    logic [7:0] d;
    logic       m;
    a = 8'h0a + 8'($unsigned($random(seed)) % 6);
    d = 8'($random(seed));
    case (a)
      8'h0b: d = i_hpcfg_loader_model.contig_mask(d[2:0], d[5:3]);
      8'h0c, 8'h0e: d = i_hpcfg_loader_model.self_value(d);
      default: ;
    endcase
    // corners: budget at and past the limit, reserved bit, controller past the limit
    if (n < 2)
    begin
      a = 8'h0c;
      d = 8'h32 + 8'(n);
    end
    else if (n == 2)
    begin
      a = 8'h0b;
      d = 8'hff;
    end
    else if (n == 3)
    begin
      a = 8'h0e;
      d = 8'h33;
    end
    sel = 1'($random(seed));
    cmp = 1'($random(seed));
    m = (a >= 8'h0b) && (a <= 8'h0e);
    // even steps read back on the very next edge, odd steps leave an idle cycle
    if (n % 2 == 0)
      i_hpcfg_loader_model.write_read(a, d, rv, rh);
    else
    begin
      i_hpcfg_loader_model.write_byte(a, d);
      i_hpcfg_loader_model.read_byte(a, rv, rh);
    end
    if (m)
      shadow[a] = (a == 8'h0b) ? (d & 8'hfe) : d;
    cmp_flag("read hit", m, rh);
    cmp_val("read data", m ? {1'b0, shadow[a]} : 9'h000, {1'b0, rv});
    check_view();
  endtask
  // all four bytes read back as zero, then the derived view
  task automatic reset_check();
    for (int j = 11; j <= 14; j++)
    begin
      shadow[j] = 8'h00;
      i_hpcfg_loader_model.read_byte(8'(j), rv, rh);
      cmp_val("reset value", 9'h000, {1'b0, rv});
      cmp_flag("reset hit", 1'b1, rh);
    end
    check_view();
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    reset_check();
    $display("test reset done");
    for (k = 0; k < 60; k++)
      one_step(k);
    $display("test random done");
    // reset again over written values, outputs checked while it is held
    SYS_RST = 1'b1;
    repeat (3) @(negedge SYS_CLK);
    cmp_val("budget in reset", 9'h000, {1'b0, budget});
    cmp_val("port off in reset", 9'h000, {1'b0, port_off});
    cmp_val("ctrl ma in reset", 9'h000, ctrl_ma);
    cmp_flag("compound in reset", 1'b0, comp_act);
    SYS_RST = 1'b0;
    reset_check();
    for (k = 60; k < 70; k++)
      one_step(k);
    $display("test mid reset done");
    finish_test();
  end
  // watchdog well past the expected run of about 270 cycles
  initial
  begin
    #(25 * 2000);
    errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
